//--- hdl/psta_table_access.sv
// Purpose: Table read and write path between the core and program memory.
// Assumes: Memory returns read data in the same cycle that mem_req.rd is high.
// Notes:   One request per cycle; every output comes from a flop.
`include "psta_cfg.svh"

module psta_table_access (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        req_valid,
  input  wire psta_pkg::psta_req_s         req,
  input  wire logic [`PSTA_PAGE_BITS-1:0]  table_page_register,
  input  wire logic                        cfg_implemented,
  input  wire logic [`PSTA_PW_BITS-1:0]    mem_rdata,
  output logic                             rd_valid_reg,
  output logic [`PSTA_DW_BITS-1:0]         rd_data_reg,
  output logic                             refused_reg,
  output psta_pkg::psta_mem_s              mem_req_reg
);

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------
  logic is_read;
  logic is_write;
  logic cfg_space;
  logic allowed;
  logic high_op;
  psta_pkg::psta_mem_s mem_next;

  // Page bit seven selects configuration space.
  assign cfg_space = table_page_register[`PSTA_CFG_SPACE_BIT];
  assign is_read   = req_valid && (req.op == psta_pkg::PSTA_OP_READ_LOW ||
                                   req.op == psta_pkg::PSTA_OP_READ_HIGH);
  assign is_write  = req_valid && (req.op == psta_pkg::PSTA_OP_WRITE_LOW ||
                                   req.op == psta_pkg::PSTA_OP_WRITE_HIGH);
  assign high_op   = req.op == psta_pkg::PSTA_OP_READ_HIGH ||
                     req.op == psta_pkg::PSTA_OP_WRITE_HIGH;
  // Config writes never pass; config reads only where implemented.
  assign allowed   = cfg_space ? (is_read && cfg_implemented) : (is_read || is_write);

  // Build the memory request; offset bit zero is the byte select, so each
  // program word spans two offset values.
  always_comb begin
    mem_next           = '0;
    mem_next.rd        = is_read && allowed;
    mem_next.wr        = is_write && allowed;
    mem_next.cfg_space = cfg_space;
    mem_next.word_addr = {table_page_register, req.offset[`PSTA_OFS_BITS-1:1]};
    // Upper byte lane is written only by the high operation.
    if (high_op) begin
      mem_next.wdata = {req.wdata[7:0], 16'h0000};
      mem_next.wbe   = 3'h4;
    end else if (req.byte_mode) begin
      mem_next.wdata = {8'h00, req.wdata[7:0], req.wdata[7:0]};
      mem_next.wbe   = req.offset[0] ? 3'h2 : 3'h1;
    end else begin
      mem_next.wdata = {8'h00, req.wdata};
      mem_next.wbe   = 3'h3;
    end
  end

  // ----------------------------------------------------------------------
  // Memory request register
  // ----------------------------------------------------------------------
  // Registered so the memory port sees clean flop outputs.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_req_reg <= '0;
    end else begin
      mem_req_reg <= mem_next;
    end
  end

  // ----------------------------------------------------------------------
  // Read context held for the returning data
  // ----------------------------------------------------------------------
  logic pend_rd_reg;
  logic pend_high_reg;
  logic pend_byte_reg;
  logic pend_sel_reg;

  // Byte select comes from the operand's address bit zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_rd_reg   <= 1'b0;
      pend_high_reg <= 1'b0;
      pend_byte_reg <= 1'b0;
      pend_sel_reg  <= 1'b0;
    end else begin
      pend_rd_reg   <= is_read && allowed;
      pend_high_reg <= high_op;
      pend_byte_reg <= req.byte_mode;
      pend_sel_reg  <= req.offset[0];
    end
  end

  // ----------------------------------------------------------------------
  // Read data steering
  // ----------------------------------------------------------------------
  function automatic logic [15:0] steer(input logic high, input logic bmode,
                                        input logic sel, input logic [23:0] w);
    logic [15:0] r;
    r = `PSTA_DATA_RST;
    if (!high) begin
      if (!bmode) r = w[15:0];
      else r = {`PSTA_ZERO_BYTE, sel ? w[15:8] : w[7:0]};
    end else begin
      if (!bmode) r = {`PSTA_ZERO_BYTE, w[23:16]};
      else r = {`PSTA_ZERO_BYTE, sel ? `PSTA_ZERO_BYTE : w[23:16]};
    end
    return r;
  endfunction

  // Refused requests and idle cycles return zero data.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= `PSTA_DATA_RST;
    end else begin
      rd_valid_reg <= pend_rd_reg;
      rd_data_reg  <= pend_rd_reg ?
                      steer(pend_high_reg, pend_byte_reg, pend_sel_reg, mem_rdata) :
                      `PSTA_DATA_RST;
    end
  end

  // Refusal is pulsed one cycle after the request.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= (is_read || is_write) && !allowed;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_cfg_write;
    req_valid && cfg_space && is_write;
  endsequence

  // A read that passes the space checks, then its two-stage answer.
  sequence s_read_taken;
    is_read && allowed;
  endsequence
  sequence s_read_answer;
    mem_req_reg.rd ##1 rd_valid_reg;
  endsequence

  AST_CFG_WRITE_BLOCK: assert property (@(posedge mclk) disable iff (rst)
    s_cfg_write |=> !mem_req_reg.wr && refused_reg)
    else $error("Configuration write was not refused.");
  AST_PAGE_ADDR: assert property (@(posedge mclk) disable iff (rst)
    (is_read && allowed) |=> mem_req_reg.word_addr[22:15] == $past(table_page_register))
    else $error("Table page not used as upper address.");
  AST_CFG_FLAG: assert property (@(posedge mclk) disable iff (rst)
    (is_read && allowed) |=> mem_req_reg.cfg_space == $past(table_page_register[7]))
    else $error("Space select does not follow page bit seven.");
  AST_CFG_UNIMPL: assert property (@(posedge mclk) disable iff (rst)
    (is_read && cfg_space && !cfg_implemented) |=> !mem_req_reg.rd ##1 !rd_valid_reg)
    else $error("Read of unimplemented configuration area executed.");
  AST_READ_LATENCY: assert property (@(posedge mclk) disable iff (rst)
    s_read_taken |=> s_read_answer)
    else $error("Read data not returned two cycles after request.");
  AST_LOW_WORD: assert property (@(posedge mclk) disable iff (rst)
    (pend_rd_reg && !pend_high_reg && !pend_byte_reg) |=> rd_data_reg == $past(mem_rdata[15:0]))
    else $error("Word read-low data mismatch.");
  AST_LOW_BYTE: assert property (@(posedge mclk) disable iff (rst)
    (pend_rd_reg && !pend_high_reg && pend_byte_reg && pend_sel_reg)
    |=> rd_data_reg == {8'h00, $past(mem_rdata[15:8])})
    else $error("Byte read-low upper byte mismatch.");
  AST_HIGH_WORD: assert property (@(posedge mclk) disable iff (rst)
    (pend_rd_reg && pend_high_reg && !pend_byte_reg)
    |=> rd_data_reg == {8'h00, $past(mem_rdata[23:16])})
    else $error("Word read-high data mismatch.");
  AST_PHANTOM: assert property (@(posedge mclk) disable iff (rst)
    (pend_rd_reg && pend_high_reg && pend_byte_reg && pend_sel_reg) |=> rd_data_reg == 16'h0000)
    else $error("Phantom byte did not read zero.");
  AST_UPPER_LANE: assert property (@(posedge mclk) disable iff (rst)
    (is_write && !high_op) |=> !mem_req_reg.wbe[2])
    else $error("Low write touched the upper program byte.");
  AST_WORD_STEP: assert property (@(posedge mclk) disable iff (rst)
    is_read |=> mem_req_reg.word_addr[14:0] == $past(req.offset[15:1]))
    else $error("Program word address is not offset over two.");

  // Byte steering with the select bit low, the idle return value, implemented config reads and the byte select source.
  AST_LOW_BYTE0: assert property (@(posedge mclk) disable iff (rst)
    (pend_rd_reg && !pend_high_reg && pend_byte_reg && !pend_sel_reg)
    |=> rd_data_reg == {8'h00, $past(mem_rdata[7:0])})
    else $error("Byte read-low lower byte mismatch.");
  AST_HIGH_BYTE0: assert property (@(posedge mclk) disable iff (rst)
    (pend_rd_reg && pend_high_reg && pend_byte_reg && !pend_sel_reg)
    |=> rd_data_reg == {8'h00, $past(mem_rdata[23:16])})
    else $error("Byte read-high upper byte mismatch.");
  AST_IDLE_ZERO: assert property (@(posedge mclk) disable iff (rst)
    !pend_rd_reg |=> !rd_valid_reg && rd_data_reg == 16'h0000)
    else $error("Read result shown without a read.");
  AST_CFG_READ_OK: assert property (@(posedge mclk) disable iff (rst)
    (is_read && cfg_space && cfg_implemented) |=> mem_req_reg.rd && !refused_reg)
    else $error("Implemented configuration read was not executed.");
  AST_BYTE_SELECT: assert property (@(posedge mclk) disable iff (rst)
    (is_read && allowed) |=> pend_sel_reg == $past(req.offset[0]))
    else $error("Byte select not taken from operand bit zero.");
  // Write lane placement for the low-word operations.
  AST_LOW_WORD_LANES: assert property (@(posedge mclk) disable iff (rst)
    (is_write && !high_op && !req.byte_mode) |=> mem_req_reg.wbe == 3'h3)
    else $error("Word write-low did not enable both low lanes.");
  AST_BYTE_LANE: assert property (@(posedge mclk) disable iff (rst)
    (is_write && !high_op && req.byte_mode)
    |=> mem_req_reg.wbe == ($past(req.offset[0]) ? 3'h2 : 3'h1))
    else $error("Byte write-low used the wrong lane.");

endmodule

//--- hdl/psta_cfg.svh
// Purpose: Constants for the program space table access block.
// Assumes: 24-bit program words, 16-bit data side, 8-bit table page.
// Notes:   Timing is one request per cycle; read data returns two cycles after the request.
`ifndef PSTA_CFG_SVH
`define PSTA_CFG_SVH

// ----------------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------------
`define PSTA_PW_BITS     24
`define PSTA_DW_BITS     16
`define PSTA_PAGE_BITS   8
`define PSTA_OFS_BITS    16
`define PSTA_CFG_SPACE_BIT 7
`define PSTA_WORD_STEP   16'h0002
`define PSTA_ZERO_BYTE   8'h00
`define PSTA_DATA_RST    16'h0000

`endif

//--- hdl/psta_pkg.sv
// Purpose: Types for the program space table access block.
// Assumes: Constants come from psta_cfg.svh.
// Notes:   Operations are one-hot coded.
`include "psta_cfg.svh"

package psta_pkg;

  // --------------------------------------------------------------------
  // Table operations
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    PSTA_OP_READ_LOW   = 4'h1,
    PSTA_OP_READ_HIGH  = 4'h2,
    PSTA_OP_WRITE_LOW  = 4'h4,
    PSTA_OP_WRITE_HIGH = 4'h8
  } psta_op_e;

  // Request from the core.
  typedef struct packed {
    psta_op_e                     op;
    logic                         byte_mode;
    logic [`PSTA_OFS_BITS-1:0]    offset;
    logic [`PSTA_DW_BITS-1:0]     wdata;
  } psta_req_s;

  // Memory-side request.
  typedef struct packed {
    logic                         rd;
    logic                         wr;
    logic                         cfg_space;
    logic [`PSTA_PAGE_BITS+`PSTA_OFS_BITS-2:0] word_addr;
    logic [`PSTA_PW_BITS-1:0]     wdata;
    logic [2:0]                   wbe;
  } psta_mem_s;

endpackage

//--- tb/psta_prog_mem.sv
// Purpose: Behavioural program memory that answers the table access block.
// Assumes: Read data is wanted in the same cycle that mem_req.rd is high.
// Notes:   Unwritten words hold an address pattern; writes merge by lane.
module psta_prog_mem (
  input  wire logic                mclk,
  input  wire psta_pkg::psta_mem_s mem_req,
  output logic [23:0]              mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] store [int];
  logic [23:0] last;
  // --------------------------------------------------------------------
  // Helpers shared with the bench mirror
  // --------------------------------------------------------------------
  function automatic logic [23:0] pat(input int a);
    return {a[7:0] ^ 8'h3c, a[15:0] ^ 16'h9e37};
  endfunction
  function automatic logic [23:0] lanes(input logic [2:0] be);
    return {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
  function automatic logic [23:0] word(input int a);
    return store.exists(a) ? store[a] : pat(a);
  endfunction
  // Blocking updates land before the block's registers move, so a read
  // issued right after a write sees the new word.
  always @(posedge mclk) begin
    if (mem_req.rd) last = word(int'(mem_req.word_addr));
    if (mem_req.wr) store[int'(mem_req.word_addr)] = (word(int'(mem_req.word_addr)) &
      ~lanes(mem_req.wbe)) | (mem_req.wdata & lanes(mem_req.wbe));
  end
  // Outside a read cycle the bus shows the inverse of the last word, never a stale copy.
  always_comb mem_rdata = mem_req.rd ? word(int'(mem_req.word_addr)) : ~last;
endmodule

//--- tb/psta_table_access_tb.sv
// Purpose: Self-checking bench for the table access block.
// Assumes: One request per cycle at most; answers at +1 and +2 cycles.
// Notes:   Random back-to-back traffic against a two-stage expected pipeline.
module psta_table_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N_CYC = 3000;
  logic                mclk, rst, req_valid, cfg_implemented;
  psta_pkg::psta_req_s req;
  logic [7:0]          table_page_register;
  logic [23:0]         mem_rdata;
  logic                rd_valid_reg, refused_reg;
  logic [15:0]         rd_data_reg;
  psta_pkg::psta_mem_s mem_req_reg;
  int                  n_mismatch, compares;
  logic [31:0]         rnd;
  logic [23:0]         mirror [int];
  logic [1:0]          e1_rw;
  logic                e1_ref, e1_rv, e1_cfg, e2_val;
  logic [15:0]         e1_dat, e2_dat;
  logic [22:0]         e1_adr;
  logic [23:0]         e1_wd;
  logic [2:0]          e1_be;
  psta_table_access psta_table_access_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req(req), .table_page_register(table_page_register), .cfg_implemented(cfg_implemented),
    .mem_rdata(mem_rdata), .rd_valid_reg(rd_valid_reg), .rd_data_reg(rd_data_reg),
    .refused_reg(refused_reg), .mem_req_reg(mem_req_reg));
  psta_prog_mem psta_prog_mem_inst (.mclk(mclk), .mem_req(mem_req_reg), .mem_rdata(mem_rdata));
  // --------------------------------------------------------------------
  // Clock, compare and closing
  // --------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One cycle: check answers of the two previous requests, then drive a new one.
  task automatic step(input logic go);
    logic [3:0]  op;
    logic [22:0] a;
    logic [23:0] w;
    logic        sel, isrd, iswr, bad;
    logic [23:0] mw, ma;
    chk({mem_req_reg.rd, mem_req_reg.wr}, e1_rw);
    chk(refused_reg, e1_ref);
    chk(rd_valid_reg, e2_val);
    chk(rd_data_reg, e2_dat);
    ma = {mem_req_reg.cfg_space, mem_req_reg.word_addr};
    mw = mem_req_reg.wdata & psta_prog_mem_inst.lanes(e1_be);
    if (e1_rw != 2'h0) chk(ma, {e1_cfg, e1_adr});
    if (e1_rw[0]) chk({mem_req_reg.wbe, mw}, {e1_be, e1_wd});
    e2_val = e1_rv;
    e2_dat = e1_dat;
    rnd = lfsr(rnd);
    op = (rnd[6:4] == 3'h0) ? 4'h3 : 4'h1 << rnd[3:2];
    req_valid = go && rnd[1:0] != 2'h0;
    req.op = psta_pkg::psta_op_e'(op);
    req.byte_mode = rnd[7];
    req.offset = {11'h000, rnd[12:9], rnd[8] && op != 4'h8};
    req.wdata = rnd[31:16] ^ rnd[15:0];
    table_page_register = {rnd[31], 6'h00, rnd[24]};
    cfg_implemented = rnd[30];
    sel = req.offset[0];
    a = {table_page_register, req.offset[15:1]};
    w = mirror.exists(int'(a)) ? mirror[int'(a)] : psta_prog_mem_inst.pat(int'(a));
    isrd = op == 4'h1 || op == 4'h2;
    iswr = op == 4'h4 || op == 4'h8;
    bad = table_page_register[7] && (iswr || !cfg_implemented);
    e1_ref = req_valid && (isrd || iswr) && bad;
    e1_rw = {req_valid && isrd && !bad, req_valid && iswr && !bad};
    e1_rv = e1_rw[1];
    e1_cfg = table_page_register[7];
    e1_adr = a;
    e1_be = op == 4'h8 ? 3'h4 : !req.byte_mode ? 3'h3 : sel ? 3'h2 : 3'h1;
    e1_wd = {req.wdata[7:0], req.byte_mode ? {2{req.wdata[7:0]}} : req.wdata} &
      psta_prog_mem_inst.lanes(e1_be);
    if (!e1_rv) e1_dat = 16'h0000;
    else if (op == 4'h1) e1_dat = !req.byte_mode ? w[15:0] : {8'h00, sel ? w[15:8] : w[7:0]};
    else e1_dat = {8'h00, (req.byte_mode && sel) ? 8'h00 : w[23:16]};
    if (e1_rw[0]) mirror[int'(a)] = (w & ~psta_prog_mem_inst.lanes(e1_be)) | e1_wd;
  endtask
  // Main sequence: reset for 12 cycles, then random back-to-back traffic.
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    table_page_register = 8'h00;
    cfg_implemented = 1'b0;
    rnd = 32'hbc16_5747;
    {e1_rw, e1_ref, e1_rv, e1_cfg, e2_val, e1_dat, e2_dat, e1_adr, e1_wd, e1_be} = '0;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    $display("Test reset done");
    for (int c = 0; c < N_CYC; c++) begin
      @(negedge mclk);
      step(c < N_CYC - 3);
    end
    $display("Test random traffic done");
    final_report();
  end
  // Watchdog: the traffic needs N_CYC cycles plus reset; beyond that it hangs.
  initial begin
    #((N_CYC + 100) * 10);
    n_mismatch++;
    final_report();
  end
endmodule
